// ==== cws_pkg.sv ====
/*
 * Shared constants, step layout and default step contents for the control write sequencer.
 * Assumes one 125 MHz clock and a host that reaches registers through a simple write/read port.
 */
package cws_pkg;

    // register offsets
    localparam logic [7:0] SOFT_RESET_ADDR = 8'h00;
    localparam logic [7:0] STEP_INDEX_CTRL_ADDR = 8'h46;
    localparam logic [7:0] STEP_TARGET_ADDR = 8'h47;
    localparam logic [7:0] STEP_PAYLOAD_ADDR = 8'h48;
    localparam logic [7:0] LAUNCH_ADDR = 8'h49;
    localparam logic [7:0] BUSY_ADDR = 8'h4A;
    localparam logic [7:0] CURRENT_INDEX_ADDR = 8'h4B;

    // field positions
    localparam int ENABLE_BIT = 8;
    localparam int LAUNCH_BIT = 8;
    localparam int ABORT_BIT = 9;
    localparam int LAST_FLAG_BIT = 14;
    localparam int WIDTH_LSB = 12;
    localparam int FIELD_LSB_LSB = 8;
    localparam int WAIT_CODE_LSB = 8;

    // memory map of step indices, dummy target register and base wait ticks
    localparam logic [5:0] RAM_LAST_INDEX = 6'h0F;
    localparam logic [5:0] ROM_LAST_INDEX = 6'h3A;
    localparam logic [7:0] DUMMY_TARGET = 8'hFF;
    localparam logic [4:0] WAIT_BASE_TICKS = 5'h08;

    // step timebase
    localparam int TIMEBASE_PS = 62500000;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int TIMEBASE_CYCLES = (TIMEBASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef struct packed {
        logic [2:0] stepFieldWidth;
        logic [3:0] stepFieldLsb;
        logic [7:0] stepTargetReg;
        logic stepLastFlag;
        logic [3:0] stepWaitCode;
        logic [7:0] stepPayload;
    } step_s;

    typedef struct packed {
        logic writeEn;
        logic [7:0] addr;
        logic [15:0] mask;
        logic [15:0] data;
    } ctrl_write_s;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_EXEC = 2'b01,
        SEQ_WAIT = 2'b10
    } seq_state_e;

    // power-up contents: start-up at 0..7, shut-down at 16..20, others a terminating dummy
    function automatic step_s defaultStep(input logic [5:0] idx);
        unique case (idx)
            6'h00: defaultStep = '{3'h0, 4'hF, 8'h4C, 1'b0, 4'h6, 8'h01};
            6'h01: defaultStep = '{3'h2, 4'h7, 8'h01, 1'b0, 4'h0, 8'h07};
            6'h02: defaultStep = '{3'h4, 4'h1, 8'h60, 1'b0, 4'h0, 8'h11};
            6'h03: defaultStep = '{3'h6, 4'h0, 8'h54, 1'b0, 4'h9, 8'h33};
            6'h04: defaultStep = '{3'h0, 4'h0, 8'hFF, 1'b0, 4'h5, 8'h00};
            6'h05: defaultStep = '{3'h0, 4'h0, 8'hFF, 1'b0, 4'h0, 8'h00};
            6'h06: defaultStep = '{3'h0, 4'h0, 8'hFF, 1'b0, 4'h0, 8'h00};
            6'h07: defaultStep = '{3'h5, 4'h2, 8'h60, 1'b1, 4'h0, 8'h3B};
            6'h10: defaultStep = '{3'h6, 4'h1, 8'h60, 1'b0, 4'h0, 8'h00};
            6'h11: defaultStep = '{3'h1, 4'h0, 8'h54, 1'b0, 4'h0, 8'h00};
            6'h12: defaultStep = '{3'h1, 4'h8, 8'h01, 1'b0, 4'h0, 8'h00};
            6'h13: defaultStep = '{3'h0, 4'hF, 8'h4C, 1'b0, 4'h0, 8'h00};
            6'h14: defaultStep = '{3'h1, 4'hC, 8'h01, 1'b1, 4'h0, 8'h00};
            default: defaultStep = '{3'h0, 4'h0, 8'hFF, 1'b1, 4'h0, 8'h00};
        endcase
    endfunction

endpackage

// ==== control_write_sequencer.sv ====
/*
 * Control write sequencer: 16 programmable RAM steps and ROM steps up to index 58, each a
 * masked field write into a control register followed by a timed wait.
 * Assumes the host register port is synchronous to clk and the control register bank
 * applies ctrlWrite as data under mask in the cycle it is seen.
 */
// Functional notes
// - write index selects RAM entry for step writes
// - width code plus one gives bits written
// - start field gives target LSB position
// - first step register low byte targets register
// - last flag halts after that step
// - step time is 62.5us times (2^D+8)
// - payload low byte; bits above width ignored
// - zero to bit 0 of FFh does nothing
// - only start..start+width-1 target bits change
// - default sequences present at power-up
// - RAM reprogrammable, kept regardless of enable
// - software reset keeps programmed RAM steps
// - start-up powers pump, driver, runs servo
// - shut-down disables drivers, servo, pump
// - launch bit runs from index, self-clears
// - start index RAM 0-15, ROM 16-58
// - busy flag reads one while running
// - abort bit stops running sequence
`timescale 1ns/100ps

module control_write_sequencer #(
    parameter int TICK_CYCLES = cws_pkg::TIMEBASE_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic oscillatorEnable,
    output logic [15:0] regRdData,
    output logic regRdValid,
    output cws_pkg::ctrl_write_s ctrlWrite,
    output logic sequencerBusyFlag,
    output logic [5:0] currentStepIndex
);

    cws_pkg::step_s [15:0] ram_q;
    cws_pkg::seq_state_e state_q;
    cws_pkg::step_s curStep;
    logic [3:0] stepWriteIndex_q;
    logic sequencerEnable_q;
    logic sequenceLaunch_q;
    logic [5:0] launchIndex_q;
    logic [15:0] tickDiv_q;
    logic [15:0] stepTicks_q;
    logic [15:0] stepTarget_q;
    logic tick;
    logic stepDone;
    logic softReset;
    logic launchReq;
    logic abortReq;

    // fetch from RAM below 16, otherwise the fixed table
    function automatic cws_pkg::step_s fetchStep(input cws_pkg::step_s [15:0] ram,
                                                 input logic [5:0] idx);
        if (idx <= cws_pkg::RAM_LAST_INDEX) begin
            fetchStep = ram[idx[3:0]];
        end else begin
            fetchStep = cws_pkg::defaultStep(idx);
        end
    endfunction

    // strobe passed in so the decode re-evaluates when the strobe alone moves
    function automatic logic isWrite(input logic wrEn, input logic [7:0] addr, input logic [7:0] target);
        isWrite = wrEn && (addr == target);
    endfunction

    assign softReset = isWrite(regWrEn, regAddr, cws_pkg::SOFT_RESET_ADDR);
    assign abortReq = isWrite(regWrEn, regAddr, cws_pkg::LAUNCH_ADDR) && regWrData[cws_pkg::ABORT_BIT];
    // reserved indices and a disabled sequencer refuse the launch
    assign launchReq = isWrite(regWrEn, regAddr, cws_pkg::LAUNCH_ADDR) && regWrData[cws_pkg::LAUNCH_BIT]
                       && !regWrData[cws_pkg::ABORT_BIT] && sequencerEnable_q
                       && (state_q == cws_pkg::SEQ_IDLE)
                       && (regWrData[5:0] <= cws_pkg::ROM_LAST_INDEX);
    assign curStep = fetchStep(ram_q, currentStepIndex);
    assign tick = (state_q == cws_pkg::SEQ_WAIT) && oscillatorEnable
                  && (tickDiv_q == 16'(TICK_CYCLES - 1));
    assign stepDone = tick && (stepTicks_q + 16'h0001 == stepTarget_q);

    // step memory: power-up defaults on rst, then host step writes; never cleared by software reset
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                ram_q[i] <= cws_pkg::defaultStep(6'(i));
            end
        end else if (regWrEn && regAddr == cws_pkg::STEP_TARGET_ADDR) begin
            ram_q[stepWriteIndex_q].stepFieldWidth <= regWrData[14:12];
            ram_q[stepWriteIndex_q].stepFieldLsb <= regWrData[11:8];
            ram_q[stepWriteIndex_q].stepTargetReg <= regWrData[7:0];
        end else if (regWrEn && regAddr == cws_pkg::STEP_PAYLOAD_ADDR) begin
            ram_q[stepWriteIndex_q].stepLastFlag <= regWrData[cws_pkg::LAST_FLAG_BIT];
            ram_q[stepWriteIndex_q].stepWaitCode <= regWrData[11:8];
            ram_q[stepWriteIndex_q].stepPayload <= regWrData[7:0];
        end
    end

    // control fields; software reset clears them but leaves the memory alone
    always_ff @(posedge clk) begin
        if (rst || softReset) begin
            stepWriteIndex_q <= 4'h0;
            sequencerEnable_q <= 1'b0;
            launchIndex_q <= 6'h00;
        end else if (regWrEn && regAddr == cws_pkg::STEP_INDEX_CTRL_ADDR) begin
            stepWriteIndex_q <= regWrData[3:0];
            sequencerEnable_q <= regWrData[cws_pkg::ENABLE_BIT];
        end else if (regWrEn && regAddr == cws_pkg::LAUNCH_ADDR) begin
            launchIndex_q <= regWrData[5:0];
        end
    end

    // sequencing state
    always_ff @(posedge clk) begin
        if (rst || softReset) begin
            state_q <= cws_pkg::SEQ_IDLE;
            sequenceLaunch_q <= 1'b0;
            currentStepIndex <= 6'h00;
            sequencerBusyFlag <= 1'b0;
        end else if (abortReq) begin
            state_q <= cws_pkg::SEQ_IDLE;
            sequenceLaunch_q <= 1'b0;
            sequencerBusyFlag <= 1'b0;
        end else begin
            unique case (state_q)
                cws_pkg::SEQ_IDLE: begin
                    if (launchReq) begin
                        state_q <= cws_pkg::SEQ_EXEC;
                        sequenceLaunch_q <= 1'b1;
                        currentStepIndex <= regWrData[5:0];
                        sequencerBusyFlag <= 1'b1;
                    end
                end
                cws_pkg::SEQ_EXEC: begin
                    state_q <= cws_pkg::SEQ_WAIT;
                end
                cws_pkg::SEQ_WAIT: begin
                    if (stepDone && curStep.stepLastFlag) begin
                        state_q <= cws_pkg::SEQ_IDLE;
                        sequenceLaunch_q <= 1'b0;
                        sequencerBusyFlag <= 1'b0;
                    end else if (stepDone) begin
                        state_q <= cws_pkg::SEQ_EXEC;
                        currentStepIndex <= currentStepIndex + 6'h01;
                    end
                end
            endcase
        end
    end

    // wait timer; the exec cycle adds one clock on top of the timebase ticks
    always_ff @(posedge clk) begin
        if (rst || state_q != cws_pkg::SEQ_WAIT || tick) begin
            tickDiv_q <= 16'h0000;
        end else if (oscillatorEnable) begin
            tickDiv_q <= tickDiv_q + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stepTicks_q <= 16'h0000;
            stepTarget_q <= 16'h0000;
        end else if (state_q == cws_pkg::SEQ_EXEC) begin
            stepTicks_q <= 16'h0000;
            stepTarget_q <= (16'h0001 << curStep.stepWaitCode) + 16'(cws_pkg::WAIT_BASE_TICKS);
        end else if (tick) begin
            stepTicks_q <= stepTicks_q + 16'h0001;
        end
    end

    // masked field write; the dummy step emits nothing
    always_ff @(posedge clk) begin
        logic [7:0] fieldMask;
        fieldMask = 8'hFF >> (3'h7 - curStep.stepFieldWidth);
        if (rst) begin
            ctrlWrite <= '0;
        end else if (state_q == cws_pkg::SEQ_EXEC && !abortReq
                     && !(curStep.stepTargetReg == cws_pkg::DUMMY_TARGET
                          && curStep.stepFieldLsb == 4'h0
                          && curStep.stepPayload[0] == 1'b0)) begin
            ctrlWrite.writeEn <= 1'b1;
            ctrlWrite.addr <= curStep.stepTargetReg;
            ctrlWrite.mask <= {8'h00, fieldMask} << curStep.stepFieldLsb;
            ctrlWrite.data <= {8'h00, curStep.stepPayload & fieldMask} << curStep.stepFieldLsb;
        end else begin
            ctrlWrite.writeEn <= 1'b0;
        end
    end

    // register readback
    always_ff @(posedge clk) begin
        cws_pkg::step_s rdStep;
        rdStep = ram_q[stepWriteIndex_q];
        if (rst) begin
            regRdData <= 16'h0000;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            unique case (regAddr)
                cws_pkg::STEP_INDEX_CTRL_ADDR: regRdData <= {7'h00, sequencerEnable_q, 4'h0, stepWriteIndex_q};
                cws_pkg::STEP_TARGET_ADDR: regRdData <= {1'b0, rdStep.stepFieldWidth, rdStep.stepFieldLsb,
                                                         rdStep.stepTargetReg};
                cws_pkg::STEP_PAYLOAD_ADDR: regRdData <= {1'b0, rdStep.stepLastFlag, 2'h0, rdStep.stepWaitCode,
                                                          rdStep.stepPayload};
                cws_pkg::LAUNCH_ADDR: regRdData <= {7'h00, sequenceLaunch_q, 2'h0, launchIndex_q};
                cws_pkg::BUSY_ADDR: regRdData <= {15'h0000, sequencerBusyFlag};
                cws_pkg::CURRENT_INDEX_ADDR: regRdData <= {10'h000, currentStepIndex};
                default: regRdData <= 16'h0000;
            endcase
        end
    end

    AST_LAUNCH_BUSY: assert property (@(posedge clk) disable iff (rst)
        launchReq && !softReset |=> sequencerBusyFlag && sequenceLaunch_q
            && currentStepIndex == $past(regWrData[5:0]))
        else $error("accepted launch did not start the sequence");

    AST_RESERVED_REFUSED: assert property (@(posedge clk) disable iff (rst)
        state_q == cws_pkg::SEQ_IDLE && regWrEn && regAddr == cws_pkg::LAUNCH_ADDR
            && regWrData[5:0] > 6'h3A |=> state_q == cws_pkg::SEQ_IDLE)
        else $error("reserved start index launched");

    AST_ABORT_STOPS: assert property (@(posedge clk) disable iff (rst)
        abortReq |=> !sequencerBusyFlag && !sequenceLaunch_q ##1 !ctrlWrite.writeEn)
        else $error("abort did not stop the sequencer");

    AST_BUSY_TRACKS: assert property (@(posedge clk) disable iff (rst)
        sequencerBusyFlag == (state_q != cws_pkg::SEQ_IDLE))
        else $error("busy flag disagrees with sequencer state");

    AST_LAST_HALTS: assert property (@(posedge clk) disable iff (rst)
        stepDone && curStep.stepLastFlag && !abortReq && !softReset
            |=> state_q == cws_pkg::SEQ_IDLE && !sequenceLaunch_q && $stable(currentStepIndex))
        else $error("last step did not halt the sequence");

    AST_ADVANCE: assert property (@(posedge clk) disable iff (rst)
        stepDone && !curStep.stepLastFlag && !abortReq && !softReset
            |=> currentStepIndex == $past(currentStepIndex) + 6'h01 && state_q == cws_pkg::SEQ_EXEC)
        else $error("sequencer did not advance to next index");

    AST_FIELD_ONLY: assert property (@(posedge clk) disable iff (rst)
        ctrlWrite.writeEn |-> (ctrlWrite.data & ~ctrlWrite.mask) == 16'h0000
            && $countones(ctrlWrite.mask) >= 1 && $countones(ctrlWrite.mask) <= 8)
        else $error("field write touches bits outside its mask");

    AST_DUMMY_SILENT: assert property (@(posedge clk) disable iff (rst)
        state_q == cws_pkg::SEQ_EXEC && curStep.stepTargetReg == 8'hFF && curStep.stepFieldLsb == 4'h0
            && !curStep.stepPayload[0] |=> !ctrlWrite.writeEn)
        else $error("dummy step produced a write");

    AST_OSC_HOLDS: assert property (@(posedge clk) disable iff (rst)
        state_q == cws_pkg::SEQ_WAIT && !oscillatorEnable && !abortReq && !softReset
            |=> $stable(tickDiv_q) && $stable(stepTicks_q))
        else $error("wait timer ran without the oscillator");

    AST_RAM_KEPT: assert property (@(posedge clk) disable iff (rst)
        softReset |=> $stable(ram_q))
        else $error("software reset altered step memory");

    AST_SOFT_RESET_CLEARS: assert property (@(posedge clk) disable iff (rst)
        softReset |=> !sequencerBusyFlag && currentStepIndex == 6'h00 && stepWriteIndex_q == 4'h0
            && !sequencerEnable_q)
        else $error("software reset left sequencer control set");

    AST_LAUNCH_CLEARED_IDLE: assert property (@(posedge clk) disable iff (rst)
        !sequencerBusyFlag |-> !sequenceLaunch_q)
        else $error("launch bit set while sequencer idle");

    AST_DISABLED_REFUSED: assert property (@(posedge clk) disable iff (rst)
        state_q == cws_pkg::SEQ_IDLE && regWrEn && regAddr == cws_pkg::LAUNCH_ADDR && !sequencerEnable_q
            |=> state_q == cws_pkg::SEQ_IDLE && !sequencerBusyFlag)
        else $error("launch accepted while sequencer disabled");

    AST_WAIT_BOUNDED: assert property (@(posedge clk) disable iff (rst)
        state_q == cws_pkg::SEQ_WAIT |-> stepTicks_q < stepTarget_q
            && stepTarget_q >= 16'(cws_pkg::WAIT_BASE_TICKS) + 16'h0001)
        else $error("step wait ran past its programmed length");

    AST_ADDR_FROM_STEP: assert property (@(posedge clk) disable iff (rst)
        ctrlWrite.writeEn |-> ctrlWrite.addr == $past(curStep.stepTargetReg))
        else $error("field write went to the wrong register");

    AST_WRITE_PULSE: assert property (@(posedge clk) disable iff (rst)
        ctrlWrite.writeEn |=> !ctrlWrite.writeEn)
        else $error("more than one field write in a step");

    AST_BUSY_READBACK: assert property (@(posedge clk) disable iff (rst)
        regRdEn && regAddr == cws_pkg::BUSY_ADDR
            |=> regRdValid && regRdData == {15'h0000, $past(sequencerBusyFlag)})
        else $error("busy flag readback wrong");

    AST_IDLE_SILENT: assert property (@(posedge clk) disable iff (rst)
        $past(state_q) == cws_pkg::SEQ_IDLE |-> !ctrlWrite.writeEn)
        else $error("field write issued while sequencer idle");

endmodule // control_write_sequencer

// ==== ctrl_reg_bank.sv ====
/*
 * Behavioural control register bank that receives the sequencer's masked writes.
 * Assumes ctrlWrite is synchronous to clk; the bench preloads and reads regs directly.
 */
`timescale 1ns/100ps

module ctrl_reg_bank (
    input wire logic clk,
    input wire cws_pkg::ctrl_write_s ctrlWrite
);
    logic [15:0] regs [256];
    int writeCount = 0;

    initial begin
        foreach (regs[i]) regs[i] = 16'h0000;
    end

    // data applied unmasked so stray bits from the sequencer show up here
    always @(posedge clk) begin
        if (ctrlWrite.writeEn === 1'b1) begin
            regs[ctrlWrite.addr] <= (regs[ctrlWrite.addr] & ~ctrlWrite.mask) | ctrlWrite.data;
            writeCount <= writeCount + 1;
        end
    end
endmodule // ctrl_reg_bank

// ==== tb.sv ====
/*
 * Self-checking bench for the control write sequencer, acting as host on the register port.
 * Assumes a short step timebase (TICK cycles) so whole sequences fit a short run.
 */
`timescale 1ns/100ps

module tb;
    localparam int TICK = 2;
    logic clk = 0;
    logic rst = 1;
    logic regWrEn = 0;
    logic regRdEn = 0;
    logic oscillatorEnable = 1;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000;
    logic [15:0] regRdData;
    logic regRdValid;
    cws_pkg::ctrl_write_s ctrlWrite;
    logic sequencerBusyFlag;
    logic [5:0] currentStepIndex;
    int fail_count = 0;
    int total_checks = 0;
    int n;

    always #4 clk = ~clk;

    control_write_sequencer #(.TICK_CYCLES(TICK)) dut (
        .clk(clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .oscillatorEnable(oscillatorEnable), .regRdData(regRdData),
        .regRdValid(regRdValid), .ctrlWrite(ctrlWrite), .sequencerBusyFlag(sequencerBusyFlag),
        .currentStepIndex(currentStepIndex)
    );

    ctrl_reg_bank bank (.clk(clk), .ctrlWrite(ctrlWrite));

    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        chk({15'h0000, regRdValid}, 16'h0001);
        chk(regRdData, exp);
    endtask

    // busy span in clocks must land in [lo, hi]
    task automatic run(input int lo, input int hi);
        chk({15'h0000, sequencerBusyFlag}, 16'h0001);
        n = 0;
        while (sequencerBusyFlag === 1'b1 && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(16'(n >= lo && n <= hi), 16'h0001);
    endtask

    initial begin
        #(8 * 10000);
        fail_count++;
        stop_test();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(8'h46, 16'h0000);
        rd(8'h4A, 16'h0000);
        rd(8'h4B, 16'h0000);
        rd(8'h40, 16'h0000);
        // power-up start-up sequence from RAM 0
        wr(8'h46, 16'h0100);
        wr(8'h49, 16'h0100);
        run(1362, 1363);
        chk(bank.regs[8'h4C], 16'h8000);
        chk(bank.regs[8'h01], 16'h0380);
        chk(bank.regs[8'h60], 16'h00EE);
        chk(bank.regs[8'h54], 16'h0033);
        chk(16'(bank.writeCount), 16'h0005);
        rd(8'h4B, 16'h0007);
        chk({10'h000, currentStepIndex}, 16'h0007);
        rd(8'h49, 16'h0000);
        // shut-down sequence from ROM 16
        foreach (bank.regs[i]) bank.regs[i] = 16'hFFFF;
        wr(8'h49, 16'h0110);
        run(95, 96);
        chk(bank.regs[8'h60], 16'hFF01);
        chk(bank.regs[8'h54], 16'hFFFC);
        chk(bank.regs[8'h01], 16'hCCFF);
        chk(bank.regs[8'h4C], 16'h7FFF);
        rd(8'h4B, 16'h0014);
        // user steps 2 and 3; payload bits above width kept on purpose
        wr(8'h46, 16'h0102);
        wr(8'h47, 16'h2E10);
        wr(8'h48, 16'h00FF);
        rd(8'h47, 16'h2E10);
        wr(8'h46, 16'h0103);
        wr(8'h47, 16'h00FF);
        wr(8'h48, 16'h4100);
        rd(8'h48, 16'h4100);
        bank.regs[8'h10] = 16'h1234;
        wr(8'h49, 16'h0102);
        run(40, 41);
        chk(bank.regs[8'h10], 16'hD234);
        chk(16'(bank.writeCount), 16'h000B);
        rd(8'h4B, 16'h0003);
        rd(8'h49, 16'h0002);
        // refused launches: disabled, reserved index, then launch with abort bit set
        wr(8'h46, 16'h0003);
        wr(8'h49, 16'h0102);
        chk({15'h0000, sequencerBusyFlag}, 16'h0000);
        rd(8'h47, 16'h00FF);
        wr(8'h46, 16'h0100);
        wr(8'h49, 16'h013B);
        chk({15'h0000, sequencerBusyFlag}, 16'h0000);
        wr(8'h49, 16'h0300);
        chk({15'h0000, sequencerBusyFlag}, 16'h0000);
        // abort in mid-step
        wr(8'h49, 16'h0100);
        repeat (10) @(posedge clk);
        wr(8'h49, 16'h0200);
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0000, sequencerBusyFlag}, 16'h0000);
        // stopped oscillator freezes the wait
        @(posedge clk);
        oscillatorEnable <= 1'b0;
        wr(8'h49, 16'h0103);
        repeat (60) @(posedge clk);
        #1;
        chk({15'h0000, sequencerBusyFlag}, 16'h0001);
        @(posedge clk);
        oscillatorEnable <= 1'b1;
        #1;
        run(18, 22);
        // software reset keeps user steps
        wr(8'h00, 16'h0000);
        rd(8'h4B, 16'h0000);
        wr(8'h46, 16'h0102);
        rd(8'h47, 16'h2E10);
        rd(8'h48, 16'h00FF);
        stop_test();
    end
endmodule // tb
